//--- verilog/ext_irq_enable_priority_ctrl.sv
// second-bank irq enables and priorities, plus external irq sensing and arbitration
`default_nettype none
`include "ext_irq_defines.svh"

module ext_irq_enable_priority_ctrl (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // special-function register port
   input wire ext_irq_pkg::sfr_byte_t sfr_addr,
   input wire ext_irq_pkg::sfr_byte_t sfr_wdata,
   input wire logic sfr_write,
   input wire logic sfr_read,
   output var ext_irq_pkg::sfr_byte_t sfr_rdata,
   output logic sfr_hit,
   // peripheral request flags
   input wire logic temp_sensor_irq_req,
   input wire logic timer_five_low_overflow_flag,
   input wire logic timer_five_high_overflow_flag,
   input wire logic timer_four_low_overflow_flag,
   input wire logic timer_four_high_overflow_flag,
   input wire logic second_smbus_unit_irq_req,
   // port 0 pins as seen by the input buffers
   input wire logic [7:0] port0_pins,
   // external irq enables and priorities held in the first bank
   input wire logic ext_irq_a_enable,
   input wire logic ext_irq_b_enable,
   input wire ext_irq_pkg::prio_t ext_irq_a_prio,
   input wire ext_irq_pkg::prio_t ext_irq_b_prio,
   // core vectoring
   input wire logic vector_ack,
   input wire ext_irq_pkg::src_id_t vector_src,
   output logic irq_req,
   output var ext_irq_pkg::src_id_t irq_src,
   output var ext_irq_pkg::prio_t irq_prio,
   // pending flags for observation
   output logic ext_irq_a_pending,
   output logic ext_irq_b_pending
);
   import ext_irq_pkg::*;

   // ---------------- register state ----------------
   sfr_byte_t enable_ff, nxt_enable;
   sfr_byte_t prio_low_ff, nxt_prio_low;
   sfr_byte_t prio_high_ff, nxt_prio_high;
   sfr_byte_t pin_cfg_ff, nxt_pin_cfg;
   logic [1:0] edge_sel_ff, nxt_edge_sel;
   logic [1:0] pending_ff, nxt_pending;
   logic [1:0] last_active_ff, nxt_last_active;
   sfr_byte_t rdata_ff, nxt_rdata;
   logic hit_ff, nxt_hit;

   // ---------------- arbitration state ----------------
   logic req_ff, nxt_req;
   src_id_t src_ff, nxt_src;
   prio_t prio_ff, nxt_prio;

   // ---------------- decode ----------------
   logic wr_enable, wr_prio_low, wr_prio_high, wr_pin_cfg, wr_timer_ctrl;
   logic [1:0] active;
   logic [2:0] pin_sel [2];
   logic [1:0] polarity;
   logic [1:0] edge_bit_w, pend_bit_w;
   logic [`NUM_SOURCES-1:0] src_req;
   prio_t src_prio [`NUM_SOURCES];

   // page bits are not part of the address, so all pages see the same registers
   always_comb begin
      wr_enable = sfr_write && (sfr_addr == `ADDR_ENABLE_BANK2);
      wr_prio_low = sfr_write && (sfr_addr == `ADDR_PRIO_LOW_BANK2);
      wr_prio_high = sfr_write && (sfr_addr == `ADDR_PRIO_HIGH_BANK2);
      wr_pin_cfg = sfr_write && (sfr_addr == `ADDR_PIN_CONFIG);
      wr_timer_ctrl = sfr_write && (sfr_addr == `ADDR_TIMER_CONTROL);
      edge_bit_w[0] = sfr_wdata[`BIT_A_EDGE_SELECT];
      edge_bit_w[1] = sfr_wdata[`BIT_B_EDGE_SELECT];
      pend_bit_w[0] = sfr_wdata[`BIT_A_PENDING];
      pend_bit_w[1] = sfr_wdata[`BIT_B_PENDING];
   end

   // pin monitor only reads the pin, so crossbar peripherals keep it
   always_comb begin
      pin_sel[0] = pin_cfg_ff[`POS_A_PIN_SELECT +: 3];
      pin_sel[1] = pin_cfg_ff[`POS_B_PIN_SELECT +: 3];
      polarity[0] = pin_cfg_ff[`BIT_A_POLARITY];
      polarity[1] = pin_cfg_ff[`BIT_B_POLARITY];
      for (int i = 0; i < 2; i++) begin
         // code n selects port 0 pin n, no remapping
         active[i] = polarity[i] ? port0_pins[pin_sel[i]] : !port0_pins[pin_sel[i]];
      end
   end

   // ---------------- register next state ----------------
   always_comb begin
      nxt_enable = wr_enable ? sfr_wdata : enable_ff;
      nxt_prio_low = wr_prio_low ? sfr_wdata : prio_low_ff;
      nxt_prio_high = wr_prio_high ? sfr_wdata : prio_high_ff;
      nxt_pin_cfg = wr_pin_cfg ? sfr_wdata : pin_cfg_ff;
      nxt_edge_sel = wr_timer_ctrl ? edge_bit_w : edge_sel_ff;
      nxt_last_active = active;
      nxt_pending = pending_ff;
      for (int i = 0; i < 2; i++) begin
         if (edge_sel_ff[i]) begin
            if (wr_timer_ctrl) begin
               nxt_pending[i] = pend_bit_w[i];
            end
            // vectoring clears, but a fresh edge in the same cycle wins
            if (vector_ack && (vector_src == 3'(i))) begin
               nxt_pending[i] = 1'b0;
            end
            if (active[i] && !last_active_ff[i]) begin
               nxt_pending[i] = 1'b1;
            end
         end else begin
            // writes are ignored here; the flag tracks the pin
            nxt_pending[i] = active[i];
         end
      end
   end

   // ---------------- read port ----------------
   always_comb begin
      nxt_rdata = 8'h00;
      nxt_hit = 1'b0;
      if (sfr_read) begin
         nxt_hit = 1'b1;
         unique case (sfr_addr)
            `ADDR_ENABLE_BANK2: nxt_rdata = enable_ff;
            `ADDR_PRIO_LOW_BANK2: nxt_rdata = prio_low_ff;
            `ADDR_PRIO_HIGH_BANK2: nxt_rdata = prio_high_ff;
            `ADDR_PIN_CONFIG: nxt_rdata = pin_cfg_ff;
            `ADDR_TIMER_CONTROL: begin
               nxt_rdata[`BIT_A_EDGE_SELECT] = edge_sel_ff[0];
               nxt_rdata[`BIT_A_PENDING] = pending_ff[0];
               nxt_rdata[`BIT_B_EDGE_SELECT] = edge_sel_ff[1];
               nxt_rdata[`BIT_B_PENDING] = pending_ff[1];
            end
            default: nxt_hit = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         enable_ff <= `RST_BANK2;
         prio_low_ff <= `RST_BANK2;
         prio_high_ff <= `RST_BANK2;
         pin_cfg_ff <= `RST_PIN_CONFIG;
         edge_sel_ff <= 2'h0;
         pending_ff <= 2'h0;
         last_active_ff <= 2'h0;
         rdata_ff <= 8'h00;
         hit_ff <= 1'b0;
      end else begin
         enable_ff <= nxt_enable;
         prio_low_ff <= nxt_prio_low;
         prio_high_ff <= nxt_prio_high;
         pin_cfg_ff <= nxt_pin_cfg;
         edge_sel_ff <= nxt_edge_sel;
         pending_ff <= nxt_pending;
         last_active_ff <= nxt_last_active;
         rdata_ff <= nxt_rdata;
         hit_ff <= nxt_hit;
      end
   end

   // ---------------- gating and priority ----------------
   // peripheral flags are cleared by their own blocks, not here
   always_comb begin
      src_req[`SRC_EXT_A] = pending_ff[0] && ext_irq_a_enable;
      src_req[`SRC_EXT_B] = pending_ff[1] && ext_irq_b_enable;
      src_req[`SRC_TEMP_SENSOR] = temp_sensor_irq_req && enable_ff[`BIT_TEMP_SENSOR];
      src_req[`SRC_TIMER_FIVE] = (timer_five_low_overflow_flag || timer_five_high_overflow_flag)
         && enable_ff[`BIT_TIMER_FIVE];
      src_req[`SRC_TIMER_FOUR] = (timer_four_low_overflow_flag || timer_four_high_overflow_flag)
         && enable_ff[`BIT_TIMER_FOUR];
      src_req[`SRC_SECOND_SMBUS] = second_smbus_unit_irq_req
         && enable_ff[`BIT_SECOND_SMBUS];
      src_prio[`SRC_EXT_A] = ext_irq_a_prio;
      src_prio[`SRC_EXT_B] = ext_irq_b_prio;
      src_prio[`SRC_TEMP_SENSOR] = {prio_high_ff[`BIT_TEMP_SENSOR],
         prio_low_ff[`BIT_TEMP_SENSOR]};
      src_prio[`SRC_TIMER_FIVE] = {prio_high_ff[`BIT_TIMER_FIVE],
         prio_low_ff[`BIT_TIMER_FIVE]};
      src_prio[`SRC_TIMER_FOUR] = {prio_high_ff[`BIT_TIMER_FOUR],
         prio_low_ff[`BIT_TIMER_FOUR]};
      src_prio[`SRC_SECOND_SMBUS] = {prio_high_ff[`BIT_SECOND_SMBUS],
         prio_low_ff[`BIT_SECOND_SMBUS]};
   end

   // ties go to the lowest source code, giving a fixed order inside a level
   always_comb begin
      nxt_req = 1'b0;
      nxt_src = 3'h0;
      nxt_prio = 2'h0;
      for (int s = 0; s < `NUM_SOURCES; s++) begin
         if (src_req[s] && (!nxt_req || (src_prio[s] > nxt_prio))) begin
            nxt_req = 1'b1;
            nxt_src = 3'(s);
            nxt_prio = src_prio[s];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         req_ff <= 1'b0;
         src_ff <= 3'h0;
         prio_ff <= 2'h0;
      end else begin
         req_ff <= nxt_req;
         src_ff <= nxt_src;
         prio_ff <= nxt_prio;
      end
   end

   // a level source still active after service simply requests again
   assign irq_req = req_ff;
   assign irq_src = src_ff;
   assign irq_prio = prio_ff;
   assign ext_irq_a_pending = pending_ff[0];
   assign ext_irq_b_pending = pending_ff[1];
   assign sfr_rdata = rdata_ff;
   assign sfr_hit = hit_ff;

endmodule : ext_irq_enable_priority_ctrl
`default_nettype wire

//--- inc/ext_irq_defines.svh
// register offsets, field positions, reset values and source codes for the external irq block
`ifndef EXT_IRQ_DEFINES_SVH
`define EXT_IRQ_DEFINES_SVH

// special-function addresses, valid on every register page
`define ADDR_PRIO_HIGH_BANK2 8'h86
`define ADDR_ENABLE_BANK2 8'hAF
`define ADDR_PRIO_LOW_BANK2 8'hBF
`define ADDR_PIN_CONFIG 8'hE4
`define ADDR_TIMER_CONTROL 8'h88

// reset values
`define RST_BANK2 8'h00
`define RST_PIN_CONFIG 8'h01
`define RST_TIMER_CONTROL 4'h0

// bit positions shared by enable, priority-low and priority-high registers
`define BIT_TEMP_SENSOR 3
`define BIT_TIMER_FIVE 2
`define BIT_TIMER_FOUR 1
`define BIT_SECOND_SMBUS 0

// timer control register: edge select at 2*i, pending at 2*i+1
`define BIT_A_EDGE_SELECT 0
`define BIT_A_PENDING 1
`define BIT_B_EDGE_SELECT 2
`define BIT_B_PENDING 3

// pin configuration register fields
`define POS_A_PIN_SELECT 0
`define BIT_A_POLARITY 3
`define POS_B_PIN_SELECT 4
`define BIT_B_POLARITY 7

// source codes presented to the core
`define SRC_EXT_A 3'h0
`define SRC_EXT_B 3'h1
`define SRC_TEMP_SENSOR 3'h2
`define SRC_TIMER_FIVE 3'h3
`define SRC_TIMER_FOUR 3'h4
`define SRC_SECOND_SMBUS 3'h5
`define NUM_SOURCES 6

`endif

//--- inc/ext_irq_pkg.sv
// types shared by the external irq enable and priority block
`default_nettype none
package ext_irq_pkg;
   typedef logic [7:0] sfr_byte_t;
   typedef logic [1:0] prio_t;
   typedef logic [2:0] src_id_t;
endpackage : ext_irq_pkg
`default_nettype wire

//--- verif/ext_irq_enable_priority_ctrl_props.sv
// port assertions for the external irq block
`default_nettype none
`include "ext_irq_defines.svh"
module ext_irq_enable_priority_ctrl_props (
   // clock, reset and register port
   input wire logic clock,
   input wire logic reset,
   input wire ext_irq_pkg::sfr_byte_t sfr_addr,
   input wire logic sfr_read,
   input wire ext_irq_pkg::sfr_byte_t sfr_rdata,
   input wire logic sfr_hit,
   // sources and core side
   input wire logic temp_sensor_irq_req,
   input wire logic second_smbus_unit_irq_req,
   input wire logic ext_irq_a_enable,
   input wire ext_irq_pkg::prio_t ext_irq_a_prio,
   input wire logic ext_irq_a_pending,
   input wire logic irq_req,
   input wire ext_irq_pkg::src_id_t irq_src,
   input wire ext_irq_pkg::prio_t irq_prio
);
   timeunit 1ns;
   timeprecision 1ns;
   import ext_irq_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   a_read_idle: assert property (!sfr_read |=> sfr_rdata == 8'h00 && !sfr_hit)
      else $error("read data outside a read");
   a_bank_hit: assert property (sfr_read && sfr_addr inside {8'h86, 8'hAF, 8'hBF} |=> sfr_hit)
      else $error("bank register not decoded");
   a_config_hit: assert property (sfr_read && sfr_addr == 8'hE4 |=> sfr_hit)
      else $error("pin config not decoded");
   a_unmapped_miss: assert property (sfr_read
      && !(sfr_addr inside {8'h86, 8'hAF, 8'hBF, 8'hE4, 8'h88}) |=> !sfr_hit)
      else $error("unmapped address decoded");
   a_temp_cause: assert property (irq_req && irq_src == `SRC_TEMP_SENSOR
      |-> $past(temp_sensor_irq_req))
      else $error("temp request without cause");
   a_smbus_cause: assert property (irq_req && irq_src == `SRC_SECOND_SMBUS
      |-> $past(second_smbus_unit_irq_req))
      else $error("smbus request without cause");
   a_ext_cause: assert property (irq_req && irq_src == `SRC_EXT_A
      |-> $past(ext_irq_a_pending) && $past(ext_irq_a_enable))
      else $error("ext request without pending flag");
   a_ext_prio: assert property (irq_req && irq_src == `SRC_EXT_A
      |-> irq_prio == $past(ext_irq_a_prio))
      else $error("ext request priority wrong");
endmodule : ext_irq_enable_priority_ctrl_props
`default_nettype wire

//--- verif/irq_core_model.sv
// core-side model: vectors to the presented request, then waits
`default_nettype none
module irq_core_model (
   input wire logic clock,
   input wire logic serve,
   input wire logic irq_req,
   input wire ext_irq_pkg::src_id_t irq_src,
   output var logic vector_ack,
   output var ext_irq_pkg::src_id_t vector_src
);
   timeunit 1ns;
   timeprecision 1ns;
   int gap = 0;
   initial vector_ack = 1'b0;
   initial vector_src = 3'h7;
   // gap keeps one pulse per request while the pending flag clears
   always @(negedge clock) begin
      vector_ack <= 1'b0;
      vector_src <= ~vector_src;
      gap <= (gap > 0) ? gap - 1 : 0;
      if (serve && irq_req && gap == 0) begin
         vector_ack <= 1'b1;
         vector_src <= irq_src;
         gap <= 4;
      end
   end
endmodule : irq_core_model
`default_nettype wire

//--- verif/ext_irq_enable_priority_ctrl_tb_top.sv
// self-checking bench for the external irq block
`default_nettype none
`include "ext_irq_defines.svh"
module ext_irq_enable_priority_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import ext_irq_pkg::*;
   logic clock, reset, sfr_write, sfr_read, sfr_hit, irq_req, vector_ack, serve;
   logic temp_sensor_irq_req, second_smbus_unit_irq_req, ext_irq_a_enable, ext_irq_b_enable;
   logic timer_five_low_overflow_flag, timer_five_high_overflow_flag, ext_irq_a_pending;
   logic timer_four_low_overflow_flag, timer_four_high_overflow_flag, ext_irq_b_pending;
   logic [7:0] port0_pins;
   sfr_byte_t sfr_addr, sfr_wdata, sfr_rdata;
   prio_t ext_irq_a_prio, ext_irq_b_prio, irq_prio;
   src_id_t vector_src, irq_src;
   int fail_count = 0;
   int samples_checked = 0;
   ext_irq_enable_priority_ctrl u_ext_irq_enable_priority_ctrl (.*);
   irq_core_model u_irq_core_model (.*);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input sfr_byte_t a, input sfr_byte_t d);
      @(negedge clock);
      {sfr_addr, sfr_wdata, sfr_write} = {a, d, 1'b1};
      @(negedge clock);
      sfr_write = 1'b0;
   endtask : wr
   task automatic rd(input sfr_byte_t a, input sfr_byte_t exp, input logic hit);
      @(negedge clock);
      {sfr_addr, sfr_read} = {a, 1'b1};
      @(negedge clock);
      sfr_read = 1'b0;
      chk(sfr_rdata, exp);
      chk({7'h00, sfr_hit}, {7'h00, hit});
   endtask : rd
   // the two timer flag pairs are exercised on the same half, low or high as hi selects
   task automatic set_src(input logic [3:0] v, input logic hi);
      {temp_sensor_irq_req, second_smbus_unit_irq_req} = {v[3], v[0]};
      {timer_five_low_overflow_flag, timer_five_high_overflow_flag} = {v[2] & ~hi, v[2] & hi};
      {timer_four_low_overflow_flag, timer_four_high_overflow_flag} = {v[1] & ~hi, v[1] & hi};
   endtask : set_src
   task automatic t_regs;
      sfr_byte_t a [3] = '{`ADDR_ENABLE_BANK2, `ADDR_PRIO_LOW_BANK2, `ADDR_PRIO_HIGH_BANK2};
      rd(`ADDR_PIN_CONFIG, `RST_PIN_CONFIG, 1'b1);
      foreach (a[i]) begin
         rd(a[i], `RST_BANK2, 1'b1);
         wr(a[i], 8'hA5);
         rd(a[i], 8'hA5, 1'b1);
         wr(a[i], 8'h00);
      end
      wr(8'h55, 8'hFF);
      rd(8'h55, 8'h00, 1'b0);
   endtask : t_regs
   task automatic t_mask;
      for (int i = 0; i < 4; i++) begin
         set_src(4'h1 << i, i[0]);
         wr(`ADDR_ENABLE_BANK2, {4'h0, ~(4'h1 << i)});
         repeat (2) @(negedge clock);
         chk({7'h00, irq_req}, 8'h00);
         wr(`ADDR_ENABLE_BANK2, {4'h0, 4'h1 << i});
         repeat (2) @(negedge clock);
         chk({4'h0, irq_req, irq_src}, 8'(13 - i));
      end
   endtask : t_mask
   task automatic t_prio;
      set_src(4'hF, 1'b1);
      wr(`ADDR_ENABLE_BANK2, 8'h0F);
      for (int i = 0; i < 4; i++) begin
         wr(`ADDR_PRIO_LOW_BANK2, 8'h01 << i);
         repeat (2) @(negedge clock);
         chk({3'h0, irq_prio, irq_src}, 8'(13 - i));
         wr(`ADDR_PRIO_LOW_BANK2, 8'h0F);
         wr(`ADDR_PRIO_HIGH_BANK2, 8'h01 << i);
         repeat (2) @(negedge clock);
         chk({3'h0, irq_prio, irq_src}, 8'(29 - i));
         wr(`ADDR_PRIO_HIGH_BANK2, 8'h00);
      end
      set_src(4'h0, 1'b0);
   endtask : t_prio
   task automatic t_ext;
      {port0_pins, ext_irq_a_enable, ext_irq_a_prio} = {8'h00, 1'b1, 2'h2};
      // pin 5 is taken as skipped by the crossbar, so only the irq source drives it
      wr(`ADDR_PIN_CONFIG, 8'h0D);
      wr(`ADDR_TIMER_CONTROL, 8'h01);
      // clears the pending flag left by reconfiguring
      wr(`ADDR_TIMER_CONTROL, 8'h01);
      port0_pins = 8'hDF;
      repeat (3) @(negedge clock);
      chk({7'h00, ext_irq_a_pending}, 8'h00);
      port0_pins = 8'hFF;
      repeat (3) @(negedge clock);
      chk({ext_irq_a_pending, irq_req, irq_prio, 1'b0, irq_src}, 8'hE0);
      // non-blocking so the core model reads it one falling edge later, without a race
      serve <= 1'b1;
      repeat (4) @(negedge clock);
      chk({7'h00, ext_irq_a_pending}, 8'h00);
      rd(`ADDR_TIMER_CONTROL, 8'h01, 1'b1);
      wr(`ADDR_TIMER_CONTROL, 8'h00);
      wr(`ADDR_PIN_CONFIG, 8'h02);
      // ext b sits on pin 0 at a higher level than ext a, so it wins while both pend
      {ext_irq_b_enable, ext_irq_b_prio} = {1'b1, 2'h3};
      for (int i = 0; i < 3; i++) begin
         port0_pins = (i == 1) ? 8'hFA : 8'hFF;
         repeat (3) @(negedge clock);
         chk({7'h00, ext_irq_a_pending}, 8'(i == 1));
         chk({7'h00, ext_irq_b_pending}, 8'(i == 1));
         chk({2'h0, irq_req, irq_prio, irq_src}, (i == 1) ? 8'h39 : 8'h00);
         rd(`ADDR_TIMER_CONTROL, (i == 1) ? 8'h0A : 8'h00, 1'b1);
      end
   endtask : t_ext
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      {reset, port0_pins, sfr_addr, sfr_wdata} = {1'b1, 8'hFF, 16'h0000};
      {sfr_write, sfr_read, ext_irq_a_enable, ext_irq_b_enable, serve} = '0;
      {ext_irq_a_prio, ext_irq_b_prio} = '0;
      set_src(4'h0, 1'b0);
      repeat (5) @(negedge clock);
      reset = 1'b0;
      t_regs();
      t_mask();
      t_prio();
      t_ext();
      finish_test();
   end
   // the whole run needs well under a thousand cycles
   initial begin
      repeat (3000) @(posedge clock);
      fail_count++;
      finish_test();
   end
endmodule : ext_irq_enable_priority_ctrl_tb_top
bind ext_irq_enable_priority_ctrl ext_irq_enable_priority_ctrl_props u_props (.*);
`default_nettype wire
